/* File: hdl/alu_datapath.sv */
// Combinational ALU group, rotate, shift and carry-instruction result generation.
`timescale 1ns/1ns
`default_nettype none
module alu_datapath
  import flag_decode_pkg::*;
(
  input wire logic [7:0] opcode,
  input wire logic [7:0] dst_val,
  input wire logic [7:0] src_val,
  input wire logic carry_in,
  input wire logic go,
  alu_result_if.source res
);
  wire [3:0] hi = opcode[7:4];
  wire [3:0] lo = opcode[3:0];
  wire alu_cell = (lo >= FORM_FIRST) && (lo <= FORM_LAST);
  wire subtract = (hi == op_subtract) || (hi == op_subtract_with_borrow) || (hi == op_compare);
  wire use_carry = (hi == op_add_with_carry) || (hi == op_subtract_with_borrow);
  wire [7:0] b_eff = subtract ? ~src_val : src_val;
  wire cin = use_carry ? (subtract ? ~carry_in : carry_in) : subtract;
  wire [8:0] sum = {1'b0, dst_val} + {1'b0, b_eff} + {8'h00, cin};
  wire arith_op = alu_cell && ((hi <= op_subtract_with_borrow) || (hi == op_compare));
  wire logic_op = alu_cell && ((hi == op_or) || (hi == op_and) || (hi == op_xor));
  wire test_op = alu_cell && ((hi == op_test_complement_mask) || (hi == op_test_under_mask));
  wire unary = (lo == 4'h0) || (lo == 4'h1);
  wire rlc_op = unary && (hi == 4'h1);
  wire rl_op = unary && (hi == 4'h9);
  wire rrc_op = unary && (hi == 4'hc);
  wire sra_op = unary && (hi == 4'hd);
  wire rr_op = unary && (hi == 4'he);
  wire shift_op = rlc_op || rl_op || rrc_op || sra_op || rr_op;
  wire carry_op = (lo == 4'hf) && ((hi == 4'hc) || (hi == 4'hd) || (hi == 4'he));
  wire [7:0] logic_val = (hi == op_or) ? (dst_val | src_val) :
                         (hi == op_and) ? (dst_val & src_val) : (dst_val ^ src_val);
  wire [7:0] test_val = (hi == op_test_complement_mask) ? (~dst_val & src_val) :
                        (dst_val & src_val);
  wire [7:0] shift_val = rlc_op ? {dst_val[6:0], carry_in} :
                         rl_op ? {dst_val[6:0], dst_val[7]} :
                         rrc_op ? {carry_in, dst_val[7:1]} :
                         sra_op ? {dst_val[7], dst_val[7:1]} : {dst_val[0], dst_val[7:1]};
  wire shift_out = (rlc_op || rl_op) ? dst_val[7] : dst_val[0];
  wire arith_ovf = (dst_val[7] == b_eff[7]) && (sum[7] != dst_val[7]);

  assign res.valid = go;
  assign res.cls = !go ? cls_none : arith_op ? cls_arith : logic_op ? cls_logic :
                   test_op ? cls_test : shift_op ? cls_shift : carry_op ? cls_carry_op :
                   cls_none;
  assign res.value = arith_op ? sum[7:0] : logic_op ? logic_val :
                     test_op ? test_val : shift_val;
  assign res.carry_out = shift_op ? shift_out : (subtract ? ~sum[8] : sum[8]);
  assign res.overflow = shift_op ? (shift_val[7] ^ dst_val[7]) : arith_ovf;
  assign res.carry_cmd = (hi == 4'hd) ? carry_set : (hi == 4'hc) ? carry_clear : carry_invert;
endmodule
`default_nettype wire

/* File: hdl/alu_result_if.sv */
// Result and flag update carried from the ALU datapath to the status register.
`timescale 1ns/1ns
`default_nettype none
interface alu_result_if;
  import flag_decode_pkg::*;
  logic valid;
  flag_class_type cls;
  logic [7:0] value;
  logic carry_out;
  logic overflow;
  carry_cmd_type carry_cmd;
  modport source (output valid, cls, value, carry_out, overflow, carry_cmd);
  modport sink (input valid, cls, value, carry_out, overflow, carry_cmd);
endinterface
`default_nettype wire

/* File: hdl/cpu_flag_and_operand_decode.sv */
// Status flag register with operand-range and ALU opcode decoding.
// Operation
// - Overflow in bit 4 on signed range overflow.
// - Logic instructions clear the overflow flag.
// - Result MSB copied into sign bit 5.
// - Zero flag bit 6 on zero arithmetic result.
// - Bit tests and shifts set zero too.
// - Carry bit 7 from carry or borrow.
// - Shifts load carry with bit shifted out.
// - Instructions set, clear or invert carry.
// - Register address 0-255, working index 0-15.
// - Register pairs only at even addresses.
// - Direct and long index addresses 13 bits.
// - Relative target is next address plus offset.
// - Short index adds signed displacement to pair.
// - Immediate operands are 8-bit constants.
// - ALU group decoded from opcode nibbles.
// - Flag write collision gives unpredictable status; here the updated flag bits win and the other bits take the written value.
`timescale 1ns/1ns
`default_nettype none
module cpu_flag_and_operand_decode
  import flag_decode_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Instruction execution.
  input wire logic exec,
  input wire logic [7:0] opcode,
  input wire logic [7:0] dst_val,
  input wire logic [7:0] src_val,
  // Operand fields.
  input wire logic [7:0] reg_field,
  input wire logic [7:0] pair_field,
  input wire logic [7:0] imm_field,
  input wire logic [7:0] rel_offset,
  input wire logic [12:0] next_pc,
  input wire logic [12:0] direct_field,
  input wire logic [12:0] pair_base,
  // Register file access to the status register.
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  // Results.
  output logic [7:0] status,
  output logic [7:0] result,
  output logic result_valid,
  output logic [7:0] reg_index,
  output logic [3:0] wreg_index,
  output logic working_sel,
  output logic pair_ok,
  output logic [7:0] imm_value,
  output logic [12:0] rel_target,
  output logic [12:0] short_index_addr,
  output logic [12:0] direct_addr,
  output logic alu_group,
  output logic [3:0] alu_op,
  output logic [3:0] alu_form,
  output logic opcode_undefined
);
  logic [7:0] status_r, status_nxt;
  logic [7:0] result_r;
  logic result_valid_r;
  logic [7:0] reg_index_r, imm_r;
  logic [3:0] wreg_index_r, alu_op_r, alu_form_r;
  logic working_sel_r, pair_ok_r, alu_group_r, undefined_r;
  logic [12:0] rel_r, short_r, direct_r;

  alu_result_if res_if ();

  alu_datapath i_alu_datapath (
    .opcode(opcode),
    .dst_val(dst_val),
    .src_val(src_val),
    .carry_in(status_r[BIT_CARRY]),
    .go(exec),
    .res(res_if.source)
  );

  function automatic logic is_alu_op(input logic [3:0] hi);
    return (hi <= 4'h7) || (hi == 4'ha) || (hi == 4'hb);
  endfunction

  wire [3:0] op_hi = opcode[7:4];
  wire [3:0] op_lo = opcode[3:0];
  wire form_ok = (op_lo >= FORM_FIRST) && (op_lo <= FORM_LAST);
  wire alu_hit = is_alu_op(op_hi) && form_ok;
  // Defined: column f from 6f up, column 0 except 40, 80, a0 and f0, columns 2-6 in ALU rows and rows c-f, including cells not decoded here.
  wire col_f_defined = (op_hi >= 4'h6);
  wire col_0_defined = !(op_hi == 4'h4 || op_hi == 4'h8 || op_hi == 4'ha || op_hi == 4'hf);
  wire col_2_6_defined = is_alu_op(op_hi) || (op_hi >= 4'hc);
  wire undef_hit = ((op_lo == 4'hf) && !col_f_defined) ||
                   ((op_lo == 4'h0) && !col_0_defined) ||
                   (form_ok && !col_2_6_defined);
  wire sel_working = (reg_field[7:4] == 4'hc);
  wire pair_even = !pair_field[0] && (pair_field <= REG_PAIR_LAST);
  wire [12:0] rel_sum = next_pc + {{5{rel_offset[7]}}, rel_offset};
  wire [12:0] short_sum = pair_base + {{5{rel_offset[7]}}, rel_offset};
  wire flags_written = exec && (res_if.cls != cls_none);
  wire sw_write = reg_wr && (reg_addr == STATUS_ADDR);
  wire zero_res = (res_if.value == 8'h00);

  always_comb begin
    status_nxt = status_r;
    // A software write colliding with a flag update: the updated flag bits win and the other bits take the written value.
    if (sw_write) begin
      status_nxt = reg_wdata;
    end
    unique case (res_if.cls)
      cls_arith: begin
        status_nxt[BIT_OVERFLOW] = res_if.overflow;
        status_nxt[BIT_SIGN] = res_if.value[7];
        status_nxt[BIT_ZERO] = zero_res;
        status_nxt[BIT_CARRY] = res_if.carry_out;
      end
      cls_logic: begin
        status_nxt[BIT_OVERFLOW] = 1'b0;
        status_nxt[BIT_SIGN] = res_if.value[7];
        status_nxt[BIT_ZERO] = zero_res;
      end
      cls_test: begin
        status_nxt[BIT_OVERFLOW] = 1'b0;
        status_nxt[BIT_SIGN] = res_if.value[7];
        status_nxt[BIT_ZERO] = zero_res;
      end
      cls_shift: begin
        status_nxt[BIT_OVERFLOW] = res_if.overflow;
        status_nxt[BIT_SIGN] = res_if.value[7];
        status_nxt[BIT_ZERO] = zero_res;
        status_nxt[BIT_CARRY] = res_if.carry_out;
      end
      cls_carry_op: begin
        unique case (res_if.carry_cmd)
          carry_set: status_nxt[BIT_CARRY] = 1'b1;
          carry_clear: status_nxt[BIT_CARRY] = 1'b0;
          carry_invert: status_nxt[BIT_CARRY] = ~status_r[BIT_CARRY];
          default: status_nxt[BIT_CARRY] = status_r[BIT_CARRY];
        endcase
      end
      default: begin
      end
    endcase
    // Non-flag instructions fall to the default arm and keep status.
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      status_r <= STATUS_RESET;
      result_r <= 8'h00;
      result_valid_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      result_r <= res_if.value;
      result_valid_r <= flags_written && (res_if.cls != cls_carry_op);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_index_r <= 8'h00;
      wreg_index_r <= 4'h0;
      working_sel_r <= 1'b0;
      pair_ok_r <= 1'b0;
      imm_r <= 8'h00;
    end else begin
      reg_index_r <= reg_field;
      wreg_index_r <= reg_field[3:0];
      working_sel_r <= sel_working;
      pair_ok_r <= pair_even;
      imm_r <= imm_field;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rel_r <= 13'h0000;
      short_r <= 13'h0000;
      direct_r <= 13'h0000;
      alu_group_r <= 1'b0;
      alu_op_r <= 4'h0;
      alu_form_r <= 4'h0;
      undefined_r <= 1'b0;
    end else begin
      rel_r <= rel_sum;
      short_r <= short_sum;
      direct_r <= direct_field;
      alu_group_r <= alu_hit;
      alu_op_r <= op_hi;
      alu_form_r <= op_lo;
      undefined_r <= undef_hit;
    end
  end

  assign status = status_r;
  assign result = result_r;
  assign result_valid = result_valid_r;
  assign reg_index = reg_index_r;
  assign wreg_index = wreg_index_r;
  assign working_sel = working_sel_r;
  assign pair_ok = pair_ok_r;
  assign imm_value = imm_r;
  assign rel_target = rel_r;
  assign short_index_addr = short_r;
  assign direct_addr = direct_r;
  assign alu_group = alu_group_r;
  assign alu_op = alu_op_r;
  assign alu_form = alu_form_r;
  assign opcode_undefined = undefined_r;

  chk_logic_clears_v: assert property (@(posedge clk_sys) disable iff (!nrst)
    exec && res_if.cls == cls_logic |=> !status[BIT_OVERFLOW])
    else $error("Overflow not cleared after logic op.");
  chk_sign_tracks_msb: assert property (@(posedge clk_sys) disable iff (!nrst)
    exec && res_if.cls inside {cls_arith, cls_logic, cls_shift} && !sw_write
    |=> status[BIT_SIGN] == result[7])
    else $error("Sign flag differs from result MSB.");
  chk_zero_arith: assert property (@(posedge clk_sys) disable iff (!nrst)
    exec && res_if.cls inside {cls_arith, cls_logic}
    |=> status[BIT_ZERO] == (result == 8'h00))
    else $error("Zero flag wrong after ALU op.");
  chk_zero_shift: assert property (@(posedge clk_sys) disable iff (!nrst)
    exec && res_if.cls inside {cls_test, cls_shift}
    |=> status[BIT_ZERO] == (result == 8'h00))
    else $error("Zero flag wrong after test or shift.");
  chk_carry_invert: assert property (@(posedge clk_sys) disable iff (!nrst)
    exec && opcode == 8'hef |=> status[BIT_CARRY] == !$past(status[BIT_CARRY]))
    else $error("Carry not inverted.");
  chk_carry_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    exec && opcode == 8'hdf |=> status[BIT_CARRY])
    else $error("Carry not set.");
  chk_flags_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    !exec && !sw_write |=> $stable(status))
    else $error("Status changed without a cause.");
  chk_pair_even: assert property (@(posedge clk_sys) disable iff (!nrst)
    pair_field[0] |=> !pair_ok)
    else $error("Odd register pair accepted.");
  chk_rel_target: assert property (@(posedge clk_sys) disable iff (!nrst)
    1'b1 |=> rel_target ==
    13'($past(next_pc) + {{5{$past(rel_offset[7])}}, $past(rel_offset)}))
    else $error("Relative target wrong.");
  chk_alu_decode: assert property (@(posedge clk_sys) disable iff (!nrst)
    opcode == 8'hb4 ##1 opcode == 8'h87 |-> alu_group ##1 !alu_group)
    else $error("ALU group decode wrong.");
  cov_arith: cover property (@(posedge clk_sys) exec && res_if.cls == cls_arith);
  cov_shift: cover property (@(posedge clk_sys) exec && res_if.cls == cls_shift);
  cov_carry_op: cover property (@(posedge clk_sys) exec && res_if.cls == cls_carry_op);
  cov_undefined: cover property (@(posedge clk_sys) undef_hit);
endmodule
`default_nettype wire

/* File: hdl/flag_decode_pkg.sv */
// Constants and types shared by the flag and operand decode logic.
`default_nettype none
package flag_decode_pkg;
  localparam logic [7:0] STATUS_ADDR = 8'hd5;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int BIT_OVERFLOW = 4;
  localparam int BIT_SIGN = 5;
  localparam int BIT_ZERO = 6;
  localparam int BIT_CARRY = 7;
  localparam logic [3:0] FORM_FIRST = 4'h2;
  localparam logic [3:0] FORM_LAST = 4'h6;
  localparam logic [3:0] WREG_PAIR_LAST = 4'he;
  localparam logic [7:0] REG_PAIR_LAST = 8'hfe;
  localparam int ADDR_BITS = 13;

  typedef enum logic [3:0] {
    op_add = 4'h0,
    op_add_with_carry = 4'h1,
    op_subtract = 4'h2,
    op_subtract_with_borrow = 4'h3,
    op_or = 4'h4,
    op_and = 4'h5,
    op_test_complement_mask = 4'h6,
    op_test_under_mask = 4'h7,
    op_compare = 4'ha,
    op_xor = 4'hb
  } alu_op_type;

  typedef enum logic [2:0] {
    cls_none,
    cls_arith,
    cls_logic,
    cls_test,
    cls_shift,
    cls_carry_op
  } flag_class_type;

  typedef enum logic [1:0] {
    carry_set,
    carry_clear,
    carry_invert
  } carry_cmd_type;
endpackage
`default_nettype wire

/* File: test/cpu_flag_and_operand_decode_tb.sv */
// Self-checking bench for the status flag and operand decode block.
`timescale 1ns/1ns
`default_nettype none
module cpu_flag_and_operand_decode_tb;
  import flag_decode_pkg::*;
  typedef struct packed {
    logic [7:0] op, d, s, st, msk, res, rmsk;
    logic rv;
  } step_type;
  // Rows run back to back, so rows that read the carry take it from the row before them.
  localparam step_type tbl [22] = '{
    '{8'h02, 8'h7f, 8'h01, 8'h30, 8'hf0, 8'h80, 8'hff, 1'b1},
    '{8'h02, 8'hff, 8'h01, 8'hc0, 8'hf0, 8'h00, 8'hff, 1'b1},
    '{8'h12, 8'h10, 8'h03, 8'h00, 8'hf0, 8'h14, 8'hff, 1'b1},
    '{8'h22, 8'h00, 8'h01, 8'ha0, 8'hf0, 8'hff, 8'hff, 1'b1},
    '{8'h32, 8'h05, 8'h01, 8'h00, 8'hf0, 8'h03, 8'hff, 1'b1},
    '{8'h22, 8'h80, 8'h01, 8'h10, 8'hf0, 8'h7f, 8'hff, 1'b1},
    '{8'h42, 8'h0f, 8'hf0, 8'h20, 8'hf0, 8'hff, 8'hff, 1'b1},
    '{8'h02, 8'h40, 8'h40, 8'h30, 8'hf0, 8'h80, 8'hff, 1'b1},
    '{8'h52, 8'hf0, 8'h0f, 8'h40, 8'hf0, 8'h00, 8'hff, 1'b1},
    '{8'hb2, 8'hff, 8'h00, 8'h20, 8'hf0, 8'hff, 8'hff, 1'b1},
    '{8'hdf, 8'h00, 8'h00, 8'ha0, 8'hf0, 8'h00, 8'h00, 1'b0},
    '{8'hef, 8'h00, 8'h00, 8'h20, 8'hf0, 8'h00, 8'h00, 1'b0},
    '{8'hef, 8'h00, 8'h00, 8'ha0, 8'hf0, 8'h00, 8'h00, 1'b0},
    '{8'hcf, 8'h00, 8'h00, 8'h20, 8'hf0, 8'h00, 8'h00, 1'b0},
    '{8'h10, 8'h80, 8'h00, 8'hc0, 8'he0, 8'h00, 8'hff, 1'b1},
    '{8'hc0, 8'h01, 8'h00, 8'ha0, 8'he0, 8'h80, 8'hff, 1'b1},
    '{8'hd0, 8'h81, 8'h00, 8'ha0, 8'he0, 8'hc0, 8'hff, 1'b1},
    '{8'h72, 8'h0f, 8'hf0, 8'hc0, 8'hf0, 8'h00, 8'h00, 1'b1},
    '{8'h62, 8'h55, 8'h55, 8'hc0, 8'hf0, 8'h00, 8'h00, 1'b1},
    '{8'ha2, 8'h03, 8'h03, 8'h40, 8'hf0, 8'h00, 8'h00, 1'b1},
    '{8'he4, 8'h12, 8'h34, 8'h40, 8'hf0, 8'h00, 8'h00, 1'b0},
    '{8'h40, 8'h12, 8'h34, 8'h40, 8'hf0, 8'h00, 8'h00, 1'b0}
  };
  localparam logic [7:0] ops [6] = '{8'h02, 8'hb4, 8'h87, 8'h92, 8'ha6, 8'hc2};
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic exec = 1'b0;
  logic [7:0] opcode = 8'h00, dst_val = 8'h00, src_val = 8'h00;
  logic [7:0] reg_field = 8'h00, pair_field = 8'h00, imm_field = 8'h00, rel_offset = 8'h00;
  logic [12:0] next_pc = 13'h0000, direct_field = 13'h0000, pair_base = 13'h0000;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [7:0] status, result, reg_index, imm_value;
  logic [3:0] wreg_index, alu_op, alu_form;
  logic [12:0] rel_target, short_index_addr, direct_addr;
  logic result_valid, working_sel, pair_ok, alu_group, opcode_undefined;
  logic grp;
  int fails = 0;
  int compares = 0;

  cpu_flag_and_operand_decode i_cpu_flag_and_operand_decode (.clk_sys(clk_sys), .nrst(nrst),
    .exec(exec), .opcode(opcode), .dst_val(dst_val), .src_val(src_val),
    .reg_field(reg_field), .pair_field(pair_field), .imm_field(imm_field),
    .rel_offset(rel_offset), .next_pc(next_pc), .direct_field(direct_field),
    .pair_base(pair_base), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .status(status), .result(result), .result_valid(result_valid), .reg_index(reg_index),
    .wreg_index(wreg_index), .working_sel(working_sel), .pair_ok(pair_ok),
    .imm_value(imm_value), .rel_target(rel_target), .short_index_addr(short_index_addr),
    .direct_addr(direct_addr), .alu_group(alu_group), .alu_op(alu_op),
    .alu_form(alu_form), .opcode_undefined(opcode_undefined));

  always #20 clk_sys = ~clk_sys;

  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Writes one register-file location; the write lands at the first edge, then one idle edge.
  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    @(negedge clk_sys);
  endtask

  // Drives one set of operand fields and checks every decoded field one cycle later.
  task automatic fields(input logic [7:0] rf, pf, imm, rel, input logic [12:0] pc, da, pb,
                        input logic [12:0] exp_rel, exp_short, input logic sel, ok);
    reg_field = rf;
    pair_field = pf;
    imm_field = imm;
    rel_offset = rel;
    next_pc = pc;
    direct_field = da;
    pair_base = pb;
    @(negedge clk_sys);
    check(reg_index, rf);
    check(wreg_index, rf[3:0]);
    check(working_sel, sel);
    check(pair_ok, ok);
    check(imm_value, imm);
    check(rel_target, exp_rel);
    check(short_index_addr, exp_short);
    check(direct_addr, da);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #200000;
    fails++;
    stop_test;
  end

  initial begin
    repeat (2) @(negedge clk_sys);
    check(status, STATUS_RESET);
    nrst = 1'b1;
    reg_write(STATUS_ADDR, 8'h5a);
    check(status, 8'h5a);
    reg_write(8'hd4, 8'h00);
    check(status, 8'h5a);
    // A status write and a flag update in the same cycle: updated flags win.
    opcode = 8'h02;
    dst_val = 8'h01;
    src_val = 8'h01;
    exec = 1'b1;
    reg_write(STATUS_ADDR, 8'h0f);
    check(status, 8'h0f);
    for (int i = 0; i < 22; i++) begin
      opcode = tbl[i].op;
      dst_val = tbl[i].d;
      src_val = tbl[i].s;
      exec = 1'b1;
      @(negedge clk_sys);
      check(status & tbl[i].msk, tbl[i].st);
      check(status & tbl[i].msk, tbl[i].st);
      check(result & tbl[i].rmsk, tbl[i].res);
      check(result_valid, tbl[i].rv);
    end
    exec = 1'b0;
    check(opcode_undefined, 1'b1);
    for (int i = 0; i < 6; i++) begin
      opcode = ops[i];
      @(negedge clk_sys);
      grp = (ops[i][7:4] <= 4'h7 || ops[i][7:4] == 4'ha || ops[i][7:4] == 4'hb) &&
            ops[i][3:0] >= FORM_FIRST && ops[i][3:0] <= FORM_LAST;
      check(alu_group, grp);
      check(alu_op, ops[i][7:4]);
      check(alu_form, ops[i][3:0]);
    end
    opcode = 8'h02;
    @(negedge clk_sys);
    check(opcode_undefined, 1'b0);
    fields(8'hc5, 8'hfe, 8'hff, 8'h80, 13'h1000, 13'h1fff, 13'h0004, 13'h0f80, 13'h1f84,
           1'b1, 1'b1);
    fields(8'h3a, 8'h07, 8'h00, 8'h7f, 13'h1fff, 13'h0000, 13'h0010, 13'h007e, 13'h008f,
           1'b0, 1'b0);
    fields(8'h00, 8'hff, 8'h01, 8'h01, 13'h0000, 13'h0abc, 13'h0000, 13'h0001, 13'h0001,
           1'b0, 1'b0);
    check(status & 8'hf0, 8'h40);
    stop_test;
  end
endmodule
`default_nettype wire
